// ### verilog/zbpic_pkg.sv
// Purpose: shared constants and types for the peripheral interrupt chain and its bus master
// Assumes: one ref_clk domain per end; bus pins cross between ends asynchronously
// Notes: register offsets are the low byte of the I/O address within the peripheral
package zbpic_pkg;
  // register offsets within the peripheral
  localparam logic [7:0] REG_CTRL = 8'h00; // master_enable, chain_block_lower, no_vector_flag, vis
  localparam logic [7:0] REG_SRC_EN = 8'h01; // source_enable bits
  localparam logic [7:0] REG_PEND = 8'h02; // pending_flag, write one to clear
  localparam logic [7:0] REG_IUS = 8'h03; // under_service_flag, write one to clear
  localparam logic [7:0] REG_VEC0 = 8'h04; // vector 0
  localparam logic [7:0] REG_VEC1 = 8'h05; // vector 1
  localparam logic [7:0] REG_POLL = 8'h06; // read only poll register
  // control register field positions
  localparam int CTRL_MIE = 0; // master_enable
  localparam int CTRL_DLC = 1; // chain_block_lower
  localparam int CTRL_NV = 2; // no_vector_flag
  localparam int CTRL_VIS0 = 3; // vector_has_status of vector 0
  localparam int CTRL_VIS1 = 4; // vector_has_status of vector 1
  localparam int POLL_ANY = 7; // poll: some source pending and enabled
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] VEC_RST = 8'h00;
  localparam logic [15:0] AD_IDLE = 16'hFFFF; // pulled-up level of a floating bus
  // cycle counts
  localparam int SYNC_LEN = 3; // pin synchroniser depth
  localparam logic [3:0] PHASE_CYC = 4'h6; // cycles each bus phase lasts
  localparam logic [3:0] RESET_HOLD_CYC = 4'h8; // cycles both strobes stay low for reset
  // master states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_HOLD = 3'h2,
    ST_DATA = 3'h3,
    ST_EXTRA = 3'h4,
    ST_END = 3'h5,
    ST_RESET = 3'h6
  } zbpic_state_t;
  // master request kinds
  typedef enum logic [1:0] {
    OP_MEM = 2'h0,
    OP_IO = 2'h1,
    OP_ACK = 2'h2,
    OP_RESET = 2'h3
  } zbpic_op_t;
endpackage

// ### verilog/zbpic_bus_if.sv
// Purpose: multiplexed address/data bus with interrupt chain pins
// Assumes: one peripheral and one master; ad floats high when nobody drives it
// Notes: resolves the shared lines from the output enables
`timescale 1ns/1ps
interface zbpic_bus_if;
  logic as_n; // addr_strobe_n
  logic ds_n; // data_strobe_n
  logic rw; // high = read
  logic bw; // high = byte
  logic io_cycle; // status: I/O transaction
  logic ack_cycle_n; // status: acknowledge transaction, low active
  logic chip_sel_n; // peripheral select, low active
  logic [15:0] host_ad; // master drive value
  logic host_ad_oe; // master drives ad
  logic [15:0] dev_ad; // peripheral drive value
  logic dev_ad_oe; // peripheral drives ad
  logic [15:0] ad; // resolved bus level
  logic dev_irq_oe; // peripheral pulls irq_n low
  logic irq_n; // resolved open-drain request
  logic priority_in; // chain input to the peripheral
  logic priority_out; // chain output of the peripheral
  // open-drain and three-state resolution
  assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : zbpic_pkg::AD_IDLE);
  assign irq_n = ~dev_irq_oe;
  modport dev_mp(
    input as_n, ds_n, rw, bw, io_cycle, ack_cycle_n, chip_sel_n, ad, priority_in,
    output dev_ad, dev_ad_oe, dev_irq_oe, priority_out
  );
  modport host_mp(
    input ad, irq_n, priority_out,
    output as_n, ds_n, rw, bw, io_cycle, ack_cycle_n, chip_sel_n, host_ad, host_ad_oe,
    priority_in
  );
endinterface

// ### verilog/zbpic_periph.sv
// Purpose: peripheral end: interrupt sources, priority chain, vector and register access
// Assumes: all bus pins are asynchronous to ref_clk; src_event comes from ref_clk logic
// Notes: every pin passes three flops; a bit changes once stages two and three agree
`timescale 1ns/1ps
module zbpic_periph #(
  parameter int NUM_SRC = 4, // interrupt sources, index 0 highest priority
  parameter logic [NUM_SRC-1:0] VEC_MAP = 4'b1100 // vector used by each source
) (
  input wire logic ref_clk,
  input wire logic reset,
  zbpic_bus_if.dev_mp bus,
  input wire logic [NUM_SRC-1:0] src_event,
  output logic [NUM_SRC-1:0] pending_out,
  output logic [NUM_SRC-1:0] under_service_out
);
  localparam int IDXW = $clog2(NUM_SRC); // width of a source index
  localparam int SW = 24; // synchronised pin count
  localparam logic [SW-1:0] SYNC_IDLE = 24'hFFFFFF; // strobes and selects idle high

  // lowest set bit wins: source 0 has the highest priority
  function automatic logic [IDXW-1:0] first_idx(input logic [NUM_SRC-1:0] v);
    logic [IDXW-1:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDXW'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser
  logic [SW-1:0] pin_raw; // pins as they arrive
  logic [SW-1:0] s1_ff, s2_ff, s3_ff; // three stages
  logic [SW-1:0] filt_ff; // agreed value
  logic [SW-1:0] nxt_filt;
  assign pin_raw = {bus.as_n, bus.ds_n, bus.ack_cycle_n, bus.chip_sel_n, bus.rw, bus.bw,
                    bus.io_cycle, bus.priority_in, bus.ad};
  // bits where stages two and three differ keep the old value
  assign nxt_filt = (s2_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));

  // stage one is read by stage two only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_ff <= SYNC_IDLE;
      s2_ff <= SYNC_IDLE;
      s3_ff <= SYNC_IDLE;
      filt_ff <= SYNC_IDLE;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  logic as_f, ds_f, ack_f, cs_f, rw_f, io_f, pin_f; // filtered pins
  logic [15:0] ad_f;
  assign as_f = filt_ff[23];
  assign ds_f = filt_ff[22];
  assign ack_f = filt_ff[21];
  assign cs_f = filt_ff[20];
  assign rw_f = filt_ff[19];
  assign io_f = filt_ff[17];
  assign pin_f = filt_ff[16];
  assign ad_f = filt_ff[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges and internal reset
  logic as_d_ff, ds_d_ff; // previous strobe levels
  logic as_rise, ds_fall, ds_rise;
  logic rst_i; // pin reset or both strobes low
  assign as_rise = as_f & ~as_d_ff;
  assign ds_fall = ~ds_f & ds_d_ff;
  assign ds_rise = ds_f & ~ds_d_ff;
  assign rst_i = reset | (~as_f & ~ds_f);

  // edge history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      as_d_ff <= 1'b1;
      ds_d_ff <= 1'b1;
    end else begin
      as_d_ff <= as_f;
      ds_d_ff <= ds_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction latches, taken at the address strobe rise
  logic cs_lat_ff, ack_lat_ff, io_lat_ff, rw_lat_ff; // held for the whole transaction
  logic [7:0] reg_lat_ff; // register offset
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      cs_lat_ff <= 1'b0;
      ack_lat_ff <= 1'b0;
      io_lat_ff <= 1'b0;
      rw_lat_ff <= 1'b1;
      reg_lat_ff <= 8'h00;
    end else if (as_rise) begin
      cs_lat_ff <= ~cs_f;
      ack_lat_ff <= ~ack_f;
      io_lat_ff <= io_f;
      rw_lat_ff <= rw_f;
      reg_lat_ff <= ad_f[7:0];
    end
  end

  // write data is caught while the data strobe is low; byte data sits low
  logic [7:0] wd_ff;
  logic io_wr, do_write; // write commits at the strobe rise only
  assign io_wr = cs_lat_ff & io_lat_ff & ~rw_lat_ff & ~ack_lat_ff;
  assign do_write = io_wr & ds_rise;
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      wd_ff <= 8'h00;
    end else if (io_wr & ~ds_f) begin
      wd_ff <= ad_f[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] ctrl_ff; // device-wide control
  logic [NUM_SRC-1:0] en_ff; // source_enable
  logic [7:0] vec_ff [2]; // stored vectors
  logic master_enable, chain_block_lower, nv;
  assign master_enable = ctrl_ff[zbpic_pkg::CTRL_MIE];
  assign chain_block_lower = ctrl_ff[zbpic_pkg::CTRL_DLC];
  assign nv = ctrl_ff[zbpic_pkg::CTRL_NV];

  // plain software registers
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      ctrl_ff <= zbpic_pkg::CTRL_RST;
      en_ff <= '0;
      vec_ff[0] <= zbpic_pkg::VEC_RST;
      vec_ff[1] <= zbpic_pkg::VEC_RST;
    end else if (do_write) begin
      unique case (reg_lat_ff)
        zbpic_pkg::REG_CTRL: ctrl_ff <= wd_ff;
        zbpic_pkg::REG_SRC_EN: en_ff <= wd_ff[NUM_SRC-1:0];
        zbpic_pkg::REG_VEC0: vec_ff[0] <= wd_ff;
        zbpic_pkg::REG_VEC1: vec_ff[1] <= wd_ff;
        default: ; // other offsets are not plain storage
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority chain through the sources
  logic [NUM_SRC-1:0] pend_ff, ius_ff; // pending_flag, under_service_flag
  logic [NUM_SRC:0] chain; // chain[k] is source k's priority_in
  logic [NUM_SRC-1:0] elig, req, sel;
  always_comb begin
    chain[0] = pin_f;
    for (int k = 0; k < NUM_SRC; k++) begin
      elig[k] = pend_ff[k] & en_ff[k] & master_enable;
      // a plain request never blocks the chain; only acknowledge or service does
      chain[k+1] = chain[k] & ~(ius_ff[k] | (ack_lat_ff & elig[k]));
      req[k] = elig[k] & ~ius_ff[k] & chain[k] & ~ack_lat_ff;
      sel[k] = elig[k] & ~ius_ff[k] & chain[k];
    end
  end

  logic take; // acknowledge lands on this device
  logic [IDXW-1:0] sel_idx;
  assign take = ds_fall & ack_lat_ff & (|sel);
  assign sel_idx = first_idx(sel);

  // pending: set beats a clear in the same cycle
  logic [NUM_SRC-1:0] pend_clr, ius_clr;
  assign pend_clr = (do_write && reg_lat_ff == zbpic_pkg::REG_PEND) ? wd_ff[NUM_SRC-1:0] : '0;
  assign ius_clr = (do_write && reg_lat_ff == zbpic_pkg::REG_IUS) ? wd_ff[NUM_SRC-1:0] : '0;
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      pend_ff <= '0;
    end else begin
      pend_ff <= (pend_ff & ~pend_clr) | src_event;
    end
  end

  // under service: selection sets, an I/O write clears
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      ius_ff <= '0;
    end else begin
      ius_ff <= (ius_ff & ~ius_clr) | (take ? sel : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector and read data
  logic [7:0] vec_out, rd_val;
  logic vmap, vector_has_status;
  logic [NUM_SRC-1:0] poll_src; // pending and enabled, regardless of master_enable
  assign poll_src = pend_ff & en_ff;
  always_comb begin
    vmap = VEC_MAP[sel_idx];
    vector_has_status = vmap ? ctrl_ff[zbpic_pkg::CTRL_VIS1] : ctrl_ff[zbpic_pkg::CTRL_VIS0];
    vec_out = vec_ff[vmap];
    if (vector_has_status) begin
      vec_out[IDXW:1] = sel_idx;
    end
    unique case (reg_lat_ff)
      zbpic_pkg::REG_CTRL: rd_val = ctrl_ff;
      zbpic_pkg::REG_SRC_EN: rd_val = 8'(en_ff);
      zbpic_pkg::REG_PEND: rd_val = 8'(pend_ff);
      zbpic_pkg::REG_IUS: rd_val = 8'(ius_ff);
      zbpic_pkg::REG_VEC0: rd_val = vec_ff[0];
      zbpic_pkg::REG_VEC1: rd_val = vec_ff[1];
      zbpic_pkg::REG_POLL: begin
        rd_val = 8'(first_idx(poll_src));
        rd_val[zbpic_pkg::POLL_ANY] = |poll_src;
      end
      default: rd_val = 8'h00; // unmapped offsets read zero
    endcase
  end

  // bus drive: only while the data strobe is low
  logic [15:0] ad_out_ff;
  logic ad_oe_ff;
  always_ff @(posedge ref_clk) begin
    if (rst_i || ds_rise) begin
      ad_out_ff <= 16'h0000;
      ad_oe_ff <= 1'b0;
    end else if (take) begin
      ad_out_ff <= {8'h00, vec_out};
      ad_oe_ff <= ~nv;
    end else if (ds_fall & cs_lat_ff & io_lat_ff & rw_lat_ff & ~ack_lat_ff) begin
      ad_out_ff <= {8'h00, rd_val};
      ad_oe_ff <= 1'b1;
    end
  end

  // request and chain outputs from flops
  logic irq_ff, pout_ff;
  always_ff @(posedge ref_clk) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      pout_ff <= 1'b0;
    end else begin
      irq_ff <= |req;
      pout_ff <= chain[NUM_SRC] & ~chain_block_lower;
    end
  end

  assign bus.dev_ad = ad_out_ff;
  assign bus.dev_ad_oe = ad_oe_ff;
  assign bus.dev_irq_oe = irq_ff;
  assign bus.priority_out = pout_ff;
  assign pending_out = pend_ff;
  assign under_service_out = ius_ff;
endmodule

// ### verilog/zbpic_master.sv
// Purpose: bus master end issuing memory, I/O, acknowledge, null and strobe-reset cycles
// Assumes: one request at a time; ad and irq_n arrive asynchronously
// Notes: each bus phase lasts PHASE_CYC cycles, the strobe reset RESET_HOLD_CYC, so the far end can synchronise
`timescale 1ns/1ps
module zbpic_master #(
  parameter logic [7:0] DEV_BASE = 8'h10 // upper address byte selecting the peripheral
) (
  input wire logic ref_clk,
  input wire logic reset,
  zbpic_bus_if.host_mp bus,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_read,
  input wire logic req_byte,
  input wire logic req_suppress,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic irq_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronise ad and irq_n, agreement of stages two and three
  logic [16:0] s1_ff, s2_ff, s3_ff, filt_ff;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_ff <= 17'h1FFFF;
      s2_ff <= 17'h1FFFF;
      s3_ff <= 17'h1FFFF;
      filt_ff <= 17'h1FFFF;
    end else begin
      s1_ff <= {bus.irq_n, bus.ad};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= (s2_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  zbpic_pkg::zbpic_state_t st_ff;
  logic [3:0] cnt_ff; // cycles left in the phase
  logic [1:0] op_ff;
  logic rd_ff, sup_ff, byte_ff;
  logic [15:0] wd_ff;
  logic as_ff, ds_ff, rw_ff, bw_ff, io_ff, ack_ff, cs_ff, oe_ff, rsp_ff;
  logic [15:0] ad_ff, rdata_ff;
  logic phase_end;
  assign phase_end = (cnt_ff == 4'h0);

  // one phase per state; strobes change only at phase boundaries
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_ff <= zbpic_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      op_ff <= zbpic_pkg::OP_MEM;
      rd_ff <= 1'b1;
      sup_ff <= 1'b0;
      byte_ff <= 1'b0;
      wd_ff <= 16'h0000;
      as_ff <= 1'b1;
      ds_ff <= 1'b1;
      rw_ff <= 1'b1;
      bw_ff <= 1'b0;
      io_ff <= 1'b0;
      ack_ff <= 1'b1;
      cs_ff <= 1'b1;
      oe_ff <= 1'b0;
      ad_ff <= 16'h0000;
      rsp_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      rsp_ff <= 1'b0;
      if (!phase_end) begin
        cnt_ff <= cnt_ff - 4'h1;
      end else begin
        cnt_ff <= zbpic_pkg::PHASE_CYC - 4'h1;
        unique case (st_ff)
          zbpic_pkg::ST_IDLE: begin
            cnt_ff <= 4'h0;
            if (req_valid) begin
              op_ff <= req_op;
              rd_ff <= req_read | (req_op == zbpic_pkg::OP_ACK);
              sup_ff <= req_suppress;
              byte_ff <= req_byte;
              wd_ff <= req_byte ? {8'h00, req_wdata[7:0]} : req_wdata;
              cnt_ff <= zbpic_pkg::PHASE_CYC - 4'h1;
              if (req_op == zbpic_pkg::OP_RESET) begin
                as_ff <= 1'b0;
                ds_ff <= 1'b0;
                cnt_ff <= zbpic_pkg::RESET_HOLD_CYC - 4'h1;
                st_ff <= zbpic_pkg::ST_RESET;
              end else begin
                as_ff <= 1'b0;
                rw_ff <= req_read | (req_op == zbpic_pkg::OP_ACK);
                bw_ff <= req_byte;
                io_ff <= (req_op == zbpic_pkg::OP_IO);
                ack_ff <= (req_op != zbpic_pkg::OP_ACK);
                // select stays stable across the strobe rise
                cs_ff <= !(req_op == zbpic_pkg::OP_IO && req_addr[15:8] == DEV_BASE);
                ad_ff <= req_addr;
                oe_ff <= 1'b1;
                st_ff <= zbpic_pkg::ST_ADDR;
              end
            end
          end
          zbpic_pkg::ST_ADDR: begin
            as_ff <= 1'b1; // address valid at this rise
            st_ff <= zbpic_pkg::ST_HOLD;
          end
          zbpic_pkg::ST_HOLD: begin
            ds_ff <= sup_ff;
            oe_ff <= ~rd_ff;
            ad_ff <= wd_ff;
            st_ff <= zbpic_pkg::ST_DATA;
          end
          zbpic_pkg::ST_DATA: begin
            // I/O and acknowledge get one more phase for slow peripherals
            if (op_ff == zbpic_pkg::OP_MEM) begin
              st_ff <= zbpic_pkg::ST_END;
            end else begin
              st_ff <= zbpic_pkg::ST_EXTRA;
            end
          end
          zbpic_pkg::ST_EXTRA: begin
            st_ff <= zbpic_pkg::ST_END;
          end
          zbpic_pkg::ST_END: begin
            rdata_ff <= byte_ff ? {8'h00, filt_ff[7:0]} : filt_ff[15:0];
            rsp_ff <= 1'b1;
            ds_ff <= 1'b1;
            oe_ff <= 1'b0;
            cs_ff <= 1'b1;
            ack_ff <= 1'b1;
            io_ff <= 1'b0;
            cnt_ff <= 4'h0;
            st_ff <= zbpic_pkg::ST_IDLE;
          end
          zbpic_pkg::ST_RESET: begin
            as_ff <= 1'b1;
            ds_ff <= 1'b1;
            rsp_ff <= 1'b1;
            cnt_ff <= 4'h0;
            st_ff <= zbpic_pkg::ST_IDLE;
          end
          default: st_ff <= zbpic_pkg::ST_IDLE; // unused code
        endcase
      end
    end
  end

  // ready only when idle and not leaving idle this cycle
  logic ready_ff, irq_ff;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ready_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ready_ff <= (st_ff == zbpic_pkg::ST_IDLE) && !req_valid;
      irq_ff <= ~filt_ff[16];
    end
  end

  assign bus.as_n = as_ff;
  assign bus.ds_n = ds_ff;
  assign bus.rw = rw_ff;
  assign bus.bw = bw_ff;
  assign bus.io_cycle = io_ff;
  assign bus.ack_cycle_n = ack_ff;
  assign bus.chip_sel_n = cs_ff;
  assign bus.host_ad = ad_ff;
  assign bus.host_ad_oe = oe_ff;
  assign bus.priority_in = 1'b1; // head of the chain
  assign req_ready = ready_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_data = rdata_ff;
  assign irq_seen = irq_ff;
endmodule

// ### verification/zbpic_asserts.sv
// Purpose: timing checks on the bus and the priority chain between the two ends
// Assumes: one ref_clk domain, reset synchronous high, bus phases of six cycles
// Notes: windows leave room for the three-flop pin filters in the peripheral
`timescale 1ns/1ps
module zbpic_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic as_n,
  input wire logic ds_n,
  input wire logic io_cycle,
  input wire logic ack_cycle_n,
  input wire logic chip_sel_n,
  input wire logic dev_ad_oe,
  input wire logic dev_irq_oe,
  input wire logic priority_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // acknowledge starting while a request stands
  sequence ack_open_s;
    $rose(as_n) && !ack_cycle_n && dev_irq_oe;
  endsequence
  AST_CLEAN_START: assert property ($fell(reset) |-> !priority_out && !dev_irq_oe && !dev_ad_oe)
    else $error("outputs not quiet after reset");
  AST_NO_REQ_IN_ACK: assert property (ack_open_s |-> ##8 !dev_irq_oe [*8])
    else $error("request during acknowledge");
  AST_ACK_HOLDS_CHAIN: assert property (ack_open_s |-> ##8 !priority_out [*8])
    else $error("chain not held low in acknowledge");
  AST_IUS_HOLDS_CHAIN: assert property (
    ack_open_s ##[23:25] $rose(ack_cycle_n) |-> !priority_out [*8])
    else $error("chain released while under service");
  AST_NO_DRIVE_IDLE: assert property (ds_n [*8] |-> !dev_ad_oe)
    else $error("bus driven without data strobe");
  AST_STROBE_RESET: assert property ((!as_n && !ds_n) [*8] |-> !dev_irq_oe && !dev_ad_oe)
    else $error("strobe reset ignored");
  AST_IO_EXTRA: assert property ($fell(ds_n) && io_cycle |-> ##17 !ds_n ##1 ds_n)
    else $error("io data phase not doubled");
  AST_AS_PHASE: assert property ($fell(as_n) && ds_n |-> !as_n [*6] ##1 as_n)
    else $error("address phase length wrong");
  AST_CS_STEADY: assert property ($fell(as_n) && ds_n |-> ##1 $stable(chip_sel_n) [*5])
    else $error("chip select moved in address phase");
  // main scenarios reached
  CV_ACK: cover property (ack_open_s);
  CV_STROBE_RESET: cover property ((!as_n && !ds_n) [*8]);
  CV_IO: cover property ($fell(ds_n) && io_cycle);
endmodule

// ### verification/tb_bus_peripheral_interrupt_chain.sv
// Purpose: both ends joined by the bus; registers, chain and vectors exercised
// Assumes: peripheral at upper address byte 8'h10, byte transfers only
// Notes: inputs change on the falling edge; waits are bounded
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_bus_peripheral_interrupt_chain;
  logic ref_clk, reset, req_valid, req_read, req_byte, req_suppress;
  logic req_ready, rsp_valid, irq_seen;
  logic [1:0] req_op;
  logic [15:0] req_addr, req_wdata, rsp_data;
  logic [3:0] src_event, pending_out, under_service_out;
  int bad_count = 0;
  int num_checks = 0;
  // offset, write data, read-back expected
  logic [23:0] rows [6] = '{{zbpic_pkg::REG_VEC0, 8'hA5, 8'hA5},
    {zbpic_pkg::REG_VEC1, 8'h3C, 8'h3C}, {zbpic_pkg::REG_SRC_EN, 8'h0F, 8'h0F},
    {zbpic_pkg::REG_CTRL, 8'h1C, 8'h1C}, {zbpic_pkg::REG_POLL, 8'h55, 8'h00},
    {8'h07, 8'h77, 8'h00}};
  zbpic_bus_if bus();
  zbpic_periph zbpic_periph_inst (.ref_clk, .reset, .bus(bus), .src_event, .pending_out,
    .under_service_out);
  zbpic_master zbpic_master_inst (.ref_clk, .reset, .bus(bus), .req_valid, .req_op,
    .req_addr, .req_wdata, .req_read, .req_byte, .req_suppress, .req_ready, .rsp_valid,
    .rsp_data, .irq_seen);
  zbpic_asserts zbpic_asserts_inst (.ref_clk, .reset, .as_n(bus.as_n), .ds_n(bus.ds_n),
    .io_cycle(bus.io_cycle), .ack_cycle_n(bus.ack_cycle_n), .chip_sel_n(bus.chip_sel_n),
    .dev_ad_oe(bus.dev_ad_oe), .dev_irq_oe(bus.dev_irq_oe), .priority_out(bus.priority_out));
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one falling edge of a bounded wait; a hang counts as a mismatch
  task automatic tick(inout int n);
    @(negedge ref_clk);
    n++;
    if (n > 400) begin
      bad_count++;
      conclude();
    end
  endtask
  // one whole request, held until its answer pulse
  task automatic xfer(input logic [1:0] op, input logic [7:0] off, input logic [7:0] wd,
    input logic rd, input logic sup);
    int n;
    n = 0;
    while (req_ready !== 1'b1) tick(n);
    req_op = op;
    req_addr = {8'h10, off};
    req_wdata = {8'h00, wd};
    req_read = rd;
    req_suppress = sup;
    req_valid = 1'b1;
    do tick(n); while (rsp_valid !== 1'b1);
    req_valid = 1'b0;
    // room for the late commit and the chain filters
    repeat (14) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] off, input logic [7:0] wd);
    xfer(2'h1, off, wd, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    xfer(2'h1, off, 8'h00, 1'b1, 1'b0);
    `CHK(rsp_data, {8'h00, e})
  endtask
  task automatic ack(input logic [7:0] e);
    xfer(2'h2, 8'h00, 8'h00, 1'b1, 1'b0);
    `CHK(rsp_data[7:0], e)
  endtask
  // single-cycle source events, then wait for the request line
  task automatic fire(input logic [3:0] v, input logic wait_req);
    int n;
    n = 0;
    src_event = v;
    @(negedge ref_clk);
    src_event = 4'h0;
    while (wait_req && bus.irq_n !== 1'b0) tick(n);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    {req_valid, req_read, req_suppress, req_op, req_addr, req_wdata, src_event} = '0;
    req_byte = 1'b1;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    repeat (12) @(negedge ref_clk);
    `CHK({bus.priority_out, bus.irq_n}, 2'h3)
    for (int i = 0; i < 4; i++) rd(i[7:0], 8'h00);
    // ordinary register rows, read-only and unmapped among them
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    // two sources pending: the higher one wins
    wr(zbpic_pkg::REG_VEC0, 8'hA0);
    wr(zbpic_pkg::REG_CTRL, 8'h01);
    fire(4'hA, 1'b1);
    `CHK(pending_out, 4'hA)
    `CHK(bus.priority_out, 1'b1)
    // master sees the request through its own pin filter
    repeat (6) @(negedge ref_clk);
    `CHK(irq_seen, 1'b1)
    rd(zbpic_pkg::REG_POLL, 8'h81);
    ack(8'hA0);
    `CHK(under_service_out, 4'h2)
    `CHK(bus.priority_out, 1'b0)
    wr(zbpic_pkg::REG_IUS, 8'h02);
    wr(zbpic_pkg::REG_PEND, 8'h02);
    fire(4'h0, 1'b1);
    ack(8'h3C);
    `CHK(under_service_out, 4'h8)
    wr(zbpic_pkg::REG_IUS, 8'h08);
    wr(zbpic_pkg::REG_PEND, 8'h08);
    `CHK({pending_out, under_service_out}, 8'h00)
    // status merged into the vector
    wr(zbpic_pkg::REG_CTRL, 8'h09);
    fire(4'h2, 1'b1);
    ack(8'hA2);
    wr(zbpic_pkg::REG_IUS, 8'h02);
    wr(zbpic_pkg::REG_PEND, 8'h02);
    // no vector: bus left to its pull-up
    wr(zbpic_pkg::REG_CTRL, 8'h05);
    fire(4'h1, 1'b1);
    ack(8'hFF);
    `CHK(under_service_out, 4'h1)
    wr(zbpic_pkg::REG_IUS, 8'h01);
    wr(zbpic_pkg::REG_PEND, 8'h01);
    // master enable off: pending but silent, still pollable
    wr(zbpic_pkg::REG_CTRL, 8'h00);
    fire(4'h4, 1'b0);
    repeat (20) @(negedge ref_clk);
    `CHK(bus.irq_n, 1'b1)
    `CHK(irq_seen, 1'b0)
    rd(zbpic_pkg::REG_POLL, 8'h82);
    wr(zbpic_pkg::REG_PEND, 8'h04);
    // lower chain blocked and released
    wr(zbpic_pkg::REG_CTRL, 8'h02);
    `CHK(bus.priority_out, 1'b0)
    wr(zbpic_pkg::REG_CTRL, 8'h00);
    `CHK(bus.priority_out, 1'b1)
    // suppressed write and null cycle change nothing
    xfer(2'h1, zbpic_pkg::REG_VEC1, 8'h99, 1'b0, 1'b1);
    rd(zbpic_pkg::REG_VEC1, 8'h3C);
    xfer(2'h0, zbpic_pkg::REG_VEC1, 8'h00, 1'b1, 1'b1);
    rd(zbpic_pkg::REG_VEC1, 8'h3C);
    // both strobes low resets the peripheral
    wr(zbpic_pkg::REG_CTRL, 8'h01);
    xfer(2'h3, 8'h00, 8'h00, 1'b0, 1'b0);
    rd(zbpic_pkg::REG_CTRL, 8'h00);
    conclude();
  end
endmodule
